// ### inc/smo_cfg.svh
`ifndef SMO_CFG_SVH
`define SMO_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SMO_CLK_NS 25
// Longest time a posted write may wait
`define SMO_DRAIN_NS 200
// Rounded down, at least one cycle
`define SMO_DRAIN_CYC ((`SMO_DRAIN_NS / `SMO_CLK_NS) > 0 ? \
    (`SMO_DRAIN_NS / `SMO_CLK_NS) : 1)

// ----------------------------------------
// Address, data and age widths
// ----------------------------------------
`define SMO_AGE_W 8
`define SMO_ADDR_W 10
`define SMO_DATA_W 64

`endif

// ### inc/smo_pkg.sv
`default_nettype none

package smo_pkg;

    // ----------------------------------------
    // Access kinds
    // ----------------------------------------
    typedef enum logic [2:0] {
        SMO_OP_IFETCH,
        SMO_OP_READ,
        SMO_OP_WRITE,
        SMO_OP_FULL_FENCE,
        SMO_OP_ISTREAM_FENCE,
        SMO_OP_TB_FILL
    } smo_op_t;

endpackage

`default_nettype wire

// ### inc/smo_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface smo_link_if
    import smo_pkg::*;
#(
    parameter int AW = 10,
    parameter int DW = 64
);
    logic req_valid;
    logic req_ready;
    smo_op_t req_op;
    logic [AW-1:0] req_addr;
    logic [DW-1:0] req_wdata;
    logic rsp_valid;
    logic [DW-1:0] rsp_data;

    modport mem_end (
        input req_valid,
        output req_ready,
        input req_op,
        input req_addr,
        input req_wdata,
        output rsp_valid,
        output rsp_data
    );

    modport agent_end (
        output req_valid,
        input req_ready,
        output req_op,
        output req_addr,
        output req_wdata,
        input rsp_valid,
        input rsp_data
    );
endinterface

`default_nettype wire

// ### hw/smo_mem_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "smo_cfg.svh"

module smo_mem_end
    import smo_pkg::*;
#(
    parameter int AW = `SMO_ADDR_W,
    parameter int DW = `SMO_DATA_W
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    smo_link_if.mem_end bus,
    output logic o_write_pending
);

    // ----------------------------------------
    // Constants and types
    // ----------------------------------------
    localparam logic [`SMO_AGE_W-1:0] DRAIN_LAST =
        `SMO_AGE_W'(`SMO_DRAIN_CYC - 1);

    typedef enum logic [1:0] {
        S_IDLE,
        S_FENCE
    } smo_mem_state_t;

    // ----------------------------------------
    // Storage and state
    // ----------------------------------------
    // One array serves the single agent on this bus, so each location has a single
    // access order by construction
    // one final value
    logic [DW-1:0] mem_array [0:(1<<AW)-1];

    smo_mem_state_t state_reg;
    smo_mem_state_t state_next;
    logic ready_reg;
    logic rsp_valid_reg;
    logic rsp_valid_next;
    logic [DW-1:0] rsp_data_reg;
    logic [DW-1:0] rsp_data_next;
    logic pend_reg;
    logic pend_next;
    logic [AW-1:0] pend_addr_reg;
    logic [AW-1:0] pend_addr_next;
    logic [DW-1:0] pend_data_reg;
    logic [DW-1:0] pend_data_next;
    logic [`SMO_AGE_W-1:0] age_reg;
    logic [`SMO_AGE_W-1:0] age_next;
    logic [AW-1:0] hold_addr_reg;
    logic hold_fill_reg;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire take = bus.req_valid && ready_reg;
    wire is_wr = bus.req_op == SMO_OP_WRITE;
    wire is_rd = bus.req_op == SMO_OP_READ;
    wire is_if = bus.req_op == SMO_OP_IFETCH;
    wire is_fill = bus.req_op == SMO_OP_TB_FILL;
    wire is_order = bus.req_op == SMO_OP_FULL_FENCE ||
        bus.req_op == SMO_OP_ISTREAM_FENCE || is_fill;
    wire hit = pend_reg && pend_addr_reg == bus.req_addr;
    wire [DW-1:0] mem_rd = mem_array[bus.req_addr];
    wire [DW-1:0] mem_hold = mem_array[hold_addr_reg];
    wire drain_due = pend_reg && age_reg >= DRAIN_LAST;
    wire drain_order = take && is_order;
    // Only one posted write; a new address pushes the old one out
    // posted writes drain late
    wire drain_push = take && is_wr && !hit;
    wire drain_now = pend_reg && (drain_due || drain_order || drain_push);
    wire stall_fence = drain_order && pend_reg;

    assign bus.req_ready = ready_reg;
    assign bus.rsp_valid = rsp_valid_reg;
    assign bus.rsp_data = rsp_data_reg;
    assign o_write_pending = pend_reg;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        rsp_valid_next = 1'b0;
        rsp_data_next = rsp_data_reg;
        pend_next = pend_reg;
        pend_addr_next = pend_addr_reg;
        pend_data_next = pend_data_reg;
        age_next = age_reg;
        if (pend_reg && age_reg < DRAIN_LAST) begin
            age_next = age_reg + `SMO_AGE_W'(1);
        end
        if (drain_now) begin
            pend_next = 1'b0;
        end
        case (state_reg)
            S_IDLE: begin
                if (take) begin
                    if (is_wr) begin
                        pend_next = 1'b1;
                        pend_addr_next = bus.req_addr;
                        pend_data_next = bus.req_wdata;
                        // Coalescing keeps the age so drains stay bounded
                        if (!(hit && !drain_now)) begin
                            age_next = '0;
                        end
                        rsp_valid_next = 1'b1;
                    end else if (is_rd) begin
                        rsp_data_next = hit ? pend_data_reg : mem_rd;
                        rsp_valid_next = 1'b1;
                    end else if (is_if) begin
                        rsp_data_next = mem_rd;
                        rsp_valid_next = 1'b1;
                    end else if (stall_fence) begin
                        state_next = S_FENCE;
                    end else begin
                        rsp_data_next = is_fill ? mem_rd : rsp_data_reg;
                        rsp_valid_next = 1'b1;
                    end
                end
            end
            S_FENCE: begin
                rsp_data_next = hold_fill_reg ? mem_hold : rsp_data_reg;
                rsp_valid_next = 1'b1;
                state_next = S_IDLE;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= S_IDLE;
            ready_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= '0;
        end else begin
            state_reg <= state_next;
            ready_reg <= state_next == S_IDLE;
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg <= rsp_data_next;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            pend_reg <= 1'b0;
            pend_addr_reg <= '0;
            pend_data_reg <= '0;
            age_reg <= '0;
        end else begin
            pend_reg <= pend_next;
            pend_addr_reg <= pend_addr_next;
            pend_data_reg <= pend_data_next;
            age_reg <= age_next;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            hold_addr_reg <= '0;
            hold_fill_reg <= 1'b0;
        end else if (take) begin
            hold_addr_reg <= bus.req_addr;
            hold_fill_reg <= is_fill;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (drain_now) begin
            mem_array[pend_addr_reg] <= pend_data_reg;
        end
    end

endmodule

`default_nettype wire

// ### hw/smo_dma_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "smo_cfg.svh"

module smo_dma_end
    import smo_pkg::*;
#(
    parameter int AW = `SMO_ADDR_W,
    parameter int DW = `SMO_DATA_W
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    smo_link_if.agent_end bus,
    input wire logic i_start,
    input wire logic i_to_mem,
    input wire logic [AW-1:0] i_base,
    input wire logic [AW-1:0] i_len,
    input wire logic [DW-1:0] i_fill_data,
    output logic o_word_take,
    output logic o_rd_valid,
    output logic [DW-1:0] o_rd_data,
    output logic o_busy,
    output logic o_done_irq
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {
        D_IDLE,
        D_PRE,
        D_XFER,
        D_POST
    } smo_dma_state_t;

    smo_dma_state_t state_reg;
    logic to_mem_reg;
    logic [AW-1:0] base_reg;
    logic [AW-1:0] len_reg;
    logic [AW-1:0] cnt_reg;
    logic req_valid_reg;
    smo_op_t req_op_reg;
    logic [AW-1:0] req_addr_reg;
    logic [DW-1:0] req_wdata_reg;
    logic word_take_reg;
    logic rd_valid_reg;
    logic [DW-1:0] rd_data_reg;
    logic done_reg;
    logic busy_reg;

    wire accepted = req_valid_reg && bus.req_ready;
    wire last = cnt_reg == len_reg - AW'(1);
    wire [AW-1:0] word_addr = base_reg + cnt_reg;

    assign bus.req_valid = req_valid_reg;
    assign bus.req_op = req_op_reg;
    assign bus.req_addr = req_addr_reg;
    assign bus.req_wdata = req_wdata_reg;
    assign o_word_take = word_take_reg;
    assign o_rd_valid = rd_valid_reg;
    assign o_rd_data = rd_data_reg;
    assign o_busy = busy_reg;
    assign o_done_irq = done_reg;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // One request outstanding at a time keeps each word in issue order
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= D_IDLE;
            to_mem_reg <= 1'b0;
            base_reg <= '0;
            len_reg <= '0;
            cnt_reg <= '0;
            req_valid_reg <= 1'b0;
            req_op_reg <= SMO_OP_FULL_FENCE;
            req_addr_reg <= '0;
            req_wdata_reg <= '0;
            word_take_reg <= 1'b0;
            rd_valid_reg <= 1'b0;
            rd_data_reg <= '0;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            word_take_reg <= 1'b0;
            rd_valid_reg <= 1'b0;
            done_reg <= 1'b0;
            if (accepted) begin
                req_valid_reg <= 1'b0;
            end
            case (state_reg)
                D_IDLE: begin
                    if (i_start) begin
                        to_mem_reg <= i_to_mem;
                        base_reg <= i_base;
                        len_reg <= i_len;
                        cnt_reg <= '0;
                        req_valid_reg <= 1'b1;
                        req_op_reg <= SMO_OP_FULL_FENCE;
                        state_reg <= D_PRE;
                        busy_reg <= 1'b1;
                    end
                end
                D_PRE: begin
                    if (bus.rsp_valid) begin
                        if (len_reg == '0) begin
                            done_reg <= 1'b1;
                            busy_reg <= 1'b0;
                            state_reg <= D_IDLE;
                        end else begin
                            req_valid_reg <= 1'b1;
                            req_op_reg <= to_mem_reg ? SMO_OP_WRITE :
                                SMO_OP_READ;
                            req_addr_reg <= word_addr;
                            req_wdata_reg <= i_fill_data;
                            word_take_reg <= to_mem_reg;
                            state_reg <= D_XFER;
                        end
                    end
                end
                D_XFER: begin
                    if (bus.rsp_valid) begin
                        rd_valid_reg <= !to_mem_reg;
                        rd_data_reg <= bus.rsp_data;
                        if (last && to_mem_reg) begin
                            req_valid_reg <= 1'b1;
                            req_op_reg <= SMO_OP_FULL_FENCE;
                            state_reg <= D_POST;
                        end else if (last) begin
                            done_reg <= 1'b1;
                            busy_reg <= 1'b0;
                            state_reg <= D_IDLE;
                        end else begin
                            cnt_reg <= cnt_reg + AW'(1);
                            req_valid_reg <= 1'b1;
                            req_addr_reg <= word_addr + AW'(1);
                            req_wdata_reg <= i_fill_data;
                            word_take_reg <= to_mem_reg;
                        end
                    end
                end
                D_POST: begin
                    if (bus.rsp_valid) begin
                        done_reg <= 1'b1;
                        busy_reg <= 1'b0;
                        state_reg <= D_IDLE;
                    end
                end
                default: begin
                    state_reg <= D_IDLE;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ### tb/smo_order_chk.sv
`timescale 1ns/1ps
`default_nettype none

module smo_order_chk
    import smo_pkg::*;
#(
    parameter int AW = 10,
    parameter int DW = 64
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire smo_op_t req_op,
    input wire logic [AW-1:0] req_addr,
    input wire logic [DW-1:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic [DW-1:0] rsp_data,
    input wire logic o_write_pending
);
    // ----------------------------------------
    // Helper decode
    // ----------------------------------------
    wire take = req_valid && req_ready;
    wire is_fence = req_op == SMO_OP_FULL_FENCE ||
        req_op == SMO_OP_ISTREAM_FENCE || req_op == SMO_OP_TB_FILL;
    wire stall_take = take && is_fence && o_write_pending;
    wire take_wr = take && req_op == SMO_OP_WRITE;
    wire take_rd = take && req_op == SMO_OP_READ;
    smo_op_t prev_op_reg;
    logic [AW-1:0] prev_addr_reg;
    logic [AW-1:0] wr_addr_reg;
    logic [DW-1:0] wr_data_reg;
    logic wr_seen_reg;
    wire rd_hit = take_rd && wr_seen_reg && req_addr == wr_addr_reg;

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            prev_op_reg <= SMO_OP_FULL_FENCE;
            prev_addr_reg <= '0;
        end else if (take) begin
            prev_op_reg <= req_op;
            prev_addr_reg <= req_addr;
        end
    end

    // Memory is not reset, so a hit needs a write seen since reset
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_seen_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
        end else if (take_wr) begin
            wr_seen_reg <= 1'b1;
            wr_addr_reg <= req_addr;
            wr_data_reg <= req_wdata;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    property p_read_hit;
        rd_hit |=> rsp_valid && rsp_data == $past(wr_data_reg);
    endproperty

    rsp_next_a: assert property (
        take && !stall_take |=> rsp_valid)
        else $error("response missing one cycle after take");
    fence_stall_a: assert property (
        stall_take |=> !req_ready && !o_write_pending && !rsp_valid
        ##1 rsp_valid && req_ready)
        else $error("stalled fence did not drain and answer");
    ready_drop_a: assert property (
        $fell(req_ready) |-> $past(stall_take))
        else $error("ready dropped without a stalled fence");
    read_hit_a: assert property (p_read_hit)
        else $error("read did not return latest write");
    write_drain_a: assert property (
        take_wr |=> o_write_pending ##[0:9] (!o_write_pending || take_wr))
        else $error("posted write not drained in time");
    write_order_a: assert property (
        take_wr && prev_op_reg == SMO_OP_WRITE |->
        req_addr == prev_addr_reg + 1'b1)
        else $error("block write addresses not ascending");
    close_fence_a: assert property (
        take && prev_op_reg == SMO_OP_WRITE && req_op != SMO_OP_WRITE
        |-> req_op == SMO_OP_FULL_FENCE)
        else $error("writes not closed by a full fence");
    read_fence_a: assert property (
        take_rd && prev_op_reg != SMO_OP_READ |->
        prev_op_reg == SMO_OP_FULL_FENCE)
        else $error("buffer read without a preceding fence");
    rsp_cause_a: assert property (
        rsp_valid |-> $past(take) || $past(stall_take, 2))
        else $error("response without a request");

    cover property (stall_take);
    cover property (rd_hit);
    cover property (take && prev_op_reg == SMO_OP_WRITE && is_fence);
endmodule

`default_nettype wire

// ### tb/shared_memory_ordering_test.sv
`timescale 1ns/1ps
`default_nettype none

module shared_memory_ordering_test
    import smo_pkg::*;
;
    logic i_sys_clk;
    logic i_reset;
    logic start, to_mem;
    logic [9:0] base, len;
    logic [63:0] fill;
    wire logic word_take, rd_valid, busy, done_irq, pend_a, pend_b;
    wire logic [63:0] rd_data;
    int n_errors = 0;
    int comparisons = 0;

    smo_link_if link_a ();
    smo_link_if link_b ();
    smo_mem_end smo_mem_end_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .bus(link_a), .o_write_pending(pend_a));
    smo_mem_end smo_mem_end_b_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .bus(link_b), .o_write_pending(pend_b));
    smo_dma_end smo_dma_end_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .bus(link_a), .i_start(start), .i_to_mem(to_mem), .i_base(base),
        .i_len(len), .i_fill_data(fill), .o_word_take(word_take),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_busy(busy),
        .o_done_irq(done_irq));
    smo_order_chk #(.AW(10), .DW(64)) smo_order_chk_i (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .req_valid(link_a.req_valid), .req_ready(link_a.req_ready),
        .req_op(link_a.req_op), .req_addr(link_a.req_addr),
        .req_wdata(link_a.req_wdata), .rsp_valid(link_a.rsp_valid),
        .rsp_data(link_a.rsp_data), .o_write_pending(pend_a));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    function automatic logic [63:0] pat(input int k);
        return 64'ha5a5_0000_0000_0000 | 64'(k);
    endfunction

    // Request held until the edge that takes it
    task automatic mem_op(input smo_op_t op, input logic [9:0] a,
            input logic [63:0] d, output logic [63:0] q);
        int n;
        @(negedge i_sys_clk);
        link_b.req_valid = 1'b1;
        link_b.req_op = op;
        link_b.req_addr = a;
        link_b.req_wdata = d;
        n = 0;
        while (link_b.req_ready !== 1'b1 && n < 20) begin
            @(negedge i_sys_clk);
            n++;
        end
        @(negedge i_sys_clk);
        link_b.req_valid = 1'b0;
        n = 0;
        while (link_b.rsp_valid !== 1'b1 && n < 4) begin
            @(negedge i_sys_clk);
            n++;
        end
        check({63'h0, link_b.rsp_valid}, 64'h1);
        q = link_b.rsp_data;
    endtask

    task automatic dma_run(input logic tm, input logic [9:0] b,
            input logic [9:0] l);
        int k, n;
        k = 0;
        @(negedge i_sys_clk);
        to_mem = tm;
        base = b;
        len = l;
        fill = pat(0);
        start = 1'b1;
        @(negedge i_sys_clk);
        start = 1'b0;
        for (n = 0; n < 300 && done_irq !== 1'b1; n++) begin
            @(negedge i_sys_clk);
            // Restart while busy must be ignored
            if (n == 3 && l > 10'h002) begin
                start = 1'b1;
                base = b ^ 10'h100;
            end
            if (n == 4) begin
                start = 1'b0;
                base = b;
            end
            if (word_take === 1'b1) begin
                k++;
                fill = pat(k);
            end
            if (rd_valid === 1'b1) begin
                check(rd_data, pat(k));
                k++;
            end
        end
        check({63'h0, done_irq}, 64'h1);
        check(64'(k), 64'(l));
        check({63'h0, busy}, 64'h0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_data();
        logic [63:0] q;
        mem_op(SMO_OP_WRITE, 10'h004, 64'h11, q);
        mem_op(SMO_OP_WRITE, 10'h004, 64'h22, q);
        mem_op(SMO_OP_READ, 10'h004, 64'h0, q);
        check(q, 64'h22);
        mem_op(SMO_OP_WRITE, 10'h005, 64'h33, q);
        mem_op(SMO_OP_READ, 10'h004, 64'h0, q);
        check(q, 64'h22);
        mem_op(SMO_OP_READ, 10'h005, 64'h0, q);
        check(q, 64'h33);
    endtask

    task automatic t_order();
        logic [63:0] q;
        mem_op(SMO_OP_WRITE, 10'h050, 64'h2, q);
        mem_op(SMO_OP_FULL_FENCE, 10'h000, 64'h0, q);
        mem_op(SMO_OP_WRITE, 10'h051, 64'h2, q);
        mem_op(SMO_OP_READ, 10'h051, 64'h0, q);
        check(q, 64'h2);
        mem_op(SMO_OP_FULL_FENCE, 10'h000, 64'h0, q);
        mem_op(SMO_OP_READ, 10'h050, 64'h0, q);
        check(q, 64'h2);
        mem_op(SMO_OP_WRITE, 10'h052, 64'h2, q);
        mem_op(SMO_OP_WRITE, 10'h052, 64'h3, q);
        mem_op(SMO_OP_READ, 10'h052, 64'h0, q);
        check(q, 64'h3);
        mem_op(SMO_OP_WRITE, 10'h053, 64'h4, q);
        mem_op(SMO_OP_READ, 10'h052, 64'h0, q);
        check(q, 64'h3);
        // A plain read must not drain the posted write
        check({63'h0, pend_b}, 64'h1);
    endtask

    task automatic t_istream();
        logic [63:0] q;
        mem_op(SMO_OP_FULL_FENCE, 10'h000, 64'h0, q);
        check({63'h0, pend_b}, 64'h0);
        mem_op(SMO_OP_WRITE, 10'h020, 64'ha1, q);
        mem_op(SMO_OP_FULL_FENCE, 10'h000, 64'h0, q);
        mem_op(SMO_OP_WRITE, 10'h020, 64'hb2, q);
        mem_op(SMO_OP_IFETCH, 10'h020, 64'h0, q);
        check(q, 64'ha1);
        mem_op(SMO_OP_ISTREAM_FENCE, 10'h020, 64'h0, q);
        mem_op(SMO_OP_IFETCH, 10'h020, 64'h0, q);
        check(q, 64'hb2);
    endtask

    task automatic t_fill_drain();
        logic [63:0] q;
        mem_op(SMO_OP_WRITE, 10'h030, 64'hc3, q);
        mem_op(SMO_OP_TB_FILL, 10'h030, 64'h0, q);
        check(q, 64'hc3);
        mem_op(SMO_OP_WRITE, 10'h040, 64'hd4, q);
        check({63'h0, pend_b}, 64'h1);
        repeat (12) @(negedge i_sys_clk);
        check({63'h0, pend_b}, 64'h0);
        mem_op(SMO_OP_IFETCH, 10'h040, 64'h0, q);
        check(q, 64'hd4);
    endtask

    // ----------------------------------------
    // Clock, reset, sequence
    // ----------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    // Whole run is well under two hundred cycles
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        n_errors++;
        end_sim();
    end

    initial begin
        i_reset = 1'b1;
        start = 1'b0;
        to_mem = 1'b0;
        base = 10'h000;
        len = 10'h000;
        fill = 64'h0;
        link_b.req_valid = 1'b0;
        link_b.req_op = SMO_OP_READ;
        link_b.req_addr = 10'h000;
        link_b.req_wdata = 64'h0;
        repeat (6) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_reset = 1'b0;
        t_data();
        t_order();
        t_istream();
        t_fill_drain();
        dma_run(1'b1, 10'h010, 10'h004);
        dma_run(1'b0, 10'h010, 10'h004);
        dma_run(1'b1, 10'h080, 10'h000);
        end_sim();
    end
endmodule

`default_nettype wire
